// ===== sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic alt_map_in = 1'b0;
    logic [31:0] entered_password_in = 32'h0000_0000;
    logic nv_restore_valid_in = 1'b0;
    logic [7:0] nv_restore_addr_in = 8'h00;
    logic [7:0] nv_restore_data_in = 8'h00;
    logic nv_restore_done_in = 1'b0;
    logic acc_valid_in, acc_write_in, acc_aux_in, acc_done_out, acc_permit_out, acc_own_out, nv_store_out;
    logic [7:0] acc_table_in, acc_addr_in, acc_wdata_in, acc_rdata_out, table_select_out, nv_addr_out, nv_data_out;
    logic [31:0] pw = 32'h1234_5678;
    int n_errors = 0;
    int check_count = 0;
    // aux, table, address, guarding enable bit (8 = none)
    logic [23:0] rows [18] = '{24'h1_00_00_0, 24'h1_00_7f_0, 24'h1_00_80_1, 24'h1_00_ff_1, 24'h0_01_7a_2,
        24'h0_01_7b_8, 24'h0_01_80_3, 24'h0_01_f7_3, 24'h0_01_f8_4, 24'h0_01_ff_4, 24'h0_04_80_5, 24'h0_02_c7_5,
        24'h0_03_c8_8, 24'h0_05_d0_7, 24'h0_05_d6_7, 24'h0_05_d7_8, 24'h0_05_f8_6, 24'h0_00_80_8};

    always #2 clk_in = ~clk_in;

    upag_host_model host (.clk_in(clk_in), .done_in(acc_done_out), .valid_out(acc_valid_in),
        .write_out(acc_write_in), .aux_out(acc_aux_in), .table_out(acc_table_in), .addr_out(acc_addr_in),
        .wdata_out(acc_wdata_in));

    upag_guard dut (.clk_in(clk_in), .nrst_in(nrst_in), .alt_map_in(alt_map_in),
        .entered_password_in(entered_password_in), .acc_valid_in(acc_valid_in), .acc_write_in(acc_write_in),
        .acc_aux_in(acc_aux_in), .acc_table_in(acc_table_in), .acc_addr_in(acc_addr_in),
        .acc_wdata_in(acc_wdata_in), .nv_restore_valid_in(nv_restore_valid_in),
        .nv_restore_addr_in(nv_restore_addr_in), .nv_restore_data_in(nv_restore_data_in),
        .nv_restore_done_in(nv_restore_done_in), .acc_done_out(acc_done_out), .acc_permit_out(acc_permit_out),
        .acc_own_out(acc_own_out), .acc_rdata_out(acc_rdata_out), .table_select_out(table_select_out),
        .nv_store_out(nv_store_out), .nv_addr_out(nv_addr_out), .nv_data_out(nv_data_out));

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask

    task automatic rd(input logic aux, input logic [7:0] tbl, input logic [7:0] addr);
        host.acc(1'b0, aux, tbl, addr, 8'h00);
        `CHK(acc_done_out, 1'b1)
    endtask

    task automatic wr(input logic [7:0] tbl, input logic [7:0] addr, input logic [7:0] wd);
        host.acc(1'b1, 1'b0, tbl, addr, wd);
    endtask

    // permit expected when the row's guarding bit is clear in the read-enable pattern of pass b
    function automatic logic open_exp(input logic [23:0] row, input int b);
        return !(row[3:0] < 4'h8 && (b == 8 || row[3:0] == 4'(b)));
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        `CHK(table_select_out, 8'h01)
        for (int i = 1; i < 8; i++) begin
            rd(1'b0, 8'h04, 8'(8'hc0 + i));
            `CHK(acc_rdata_out, (i == 7) ? 8'h01 : 8'h00)
        end
        $display("test factory values finished");
        for (int i = 0; i < 4; i++) wr(8'h04, 8'(8'hc3 + i), pw[8*(3-i) +: 8]);
        entered_password_in = pw;
        wr(8'h04, 8'hc1, 8'hff);
        `CHK({nv_store_out, nv_addr_out, nv_data_out}, {1'b1, 8'hc1, 8'hff})
        // one pass per read-enable bit, then all bits, each read with a wrong password
        for (int b = 0; b < 9; b++) begin
            entered_password_in = pw;
            wr(8'h04, 8'hc2, (b == 8) ? 8'hff : 8'(8'h01 << b));
            entered_password_in = 32'h0000_0000;
            for (int i = 0; i < 18; i++) begin
                rd(rows[i][20], rows[i][19:12], rows[i][11:4]);
                `CHK(acc_permit_out, open_exp(rows[i], b))
            end
        end
        $display("test block map finished");
        wr(8'h04, 8'hc1, 8'h00);
        `CHK({acc_permit_out, nv_store_out}, 2'b00)
        host.acc(1'b1, 1'b1, 8'h00, 8'h10, 8'h55);
        `CHK(acc_permit_out, 1'b0)
        host.acc(1'b1, 1'b1, 8'h00, 8'h80, 8'h55);
        `CHK(acc_permit_out, 1'b0)
        entered_password_in = 32'h7856_3412;
        rd(1'b1, 8'h00, 8'h00);
        `CHK(acc_permit_out, 1'b0)
        entered_password_in = pw;
        rd(1'b1, 8'h00, 8'h00);
        `CHK(acc_permit_out, 1'b1)
        rd(1'b0, 8'h04, 8'hc1);
        `CHK(acc_rdata_out, 8'hff)
        rd(1'b0, 8'h04, 8'hc3);
        `CHK(acc_rdata_out, 8'h12)
        $display("test password finished");
        entered_password_in = 32'h0000_0000;
        alt_map_in = 1'b1;
        rd(1'b0, 8'h01, 8'hc1);
        `CHK({acc_own_out, acc_permit_out}, 2'b10)
        rd(1'b0, 8'h00, 8'h80);
        `CHK(acc_permit_out, 1'b0)
        rd(1'b0, 8'h04, 8'hc1);
        `CHK(acc_own_out, 1'b0)
        alt_map_in = 1'b0;
        $display("test alternate map finished");
        wr(8'h04, 8'h7f, 8'h05);
        tick();
        `CHK(table_select_out, 8'h05)
        entered_password_in = pw;
        wr(8'h04, 8'hc7, 8'h03);
        nv_restore_done_in = 1'b1;
        tick();
        nv_restore_done_in = 1'b0;
        `CHK(table_select_out, 8'h03)
        nv_restore_valid_in = 1'b1;
        nv_restore_addr_in = 8'hc2;
        tick();
        nv_restore_valid_in = 1'b0;
        entered_password_in = 32'h0000_0000;
        rd(1'b1, 8'h00, 8'h00);
        `CHK(acc_permit_out, 1'b1)
        $display("test table select and restore finished");
        nrst_in = 1'b0;
        tick();
        nrst_in = 1'b1;
        `CHK(table_select_out, 8'h01)
        rd(1'b0, 8'h04, 8'hc1);
        `CHK({acc_permit_out, acc_rdata_out}, {1'b1, 8'h00})
        $display("test second reset finished");
        tally_and_finish();
    end
endmodule

// ===== sim/upag_host_model.sv
`timescale 1ns/10ps
module upag_host_model (
    input wire logic clk_in,
    input wire logic done_in,
    output logic valid_out,
    output logic write_out,
    output logic aux_out,
    output logic [7:0] table_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    initial begin
        valid_out = 1'b0;
        write_out = 1'b0;
        aux_out = 1'b0;
        table_out = 8'h00;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end

    // one byte access: request for one cycle, answer checked one edge later
    task automatic acc(input logic w, input logic aux, input logic [7:0] tbl, input logic [7:0] addr,
                       input logic [7:0] wd);
        @(posedge clk_in);
        #1;
        valid_out = 1'b1;
        write_out = w;
        aux_out = aux;
        table_out = tbl;
        addr_out = addr;
        wdata_out = wd;
        @(posedge clk_in);
        #1;
        valid_out = 1'b0;
        // released table, address and data lines do not keep the last value
        table_out = ~tbl;
        addr_out = ~addr;
        wdata_out = ~wd;
    endtask
endmodule

// ===== src/upag_defines.svh
`ifndef UPAG_DEFINES_SVH
`define UPAG_DEFINES_SVH

// byte offsets inside the configuration table
`define UPAG_OFS_WR_EN 8'hc1
`define UPAG_OFS_RD_EN 8'hc2
`define UPAG_OFS_PW_B3 8'hc3
`define UPAG_OFS_PW_B2 8'hc4
`define UPAG_OFS_PW_B1 8'hc5
`define UPAG_OFS_PW_B0 8'hc6
`define UPAG_OFS_TSEL_DEF 8'hc7

// factory values
`define UPAG_RST_WR_EN 8'h00
`define UPAG_RST_RD_EN 8'h00
`define UPAG_RST_PW 32'h0000_0000
`define UPAG_RST_TSEL_DEF 8'h01

// table numbers
`define UPAG_TBL_00 8'h00
`define UPAG_TBL_01 8'h01
`define UPAG_TBL_02 8'h02
`define UPAG_TBL_03 8'h03
`define UPAG_TBL_04 8'h04
`define UPAG_TBL_05 8'h05

// block boundaries and table select address
`define UPAG_UPPER_BASE 8'h80
`define UPAG_LOWER_LAST 8'h7a
`define UPAG_TSEL_ADDR 8'h7f
`define UPAG_T5A_FIRST 8'hd0
`define UPAG_T5A_LAST 8'hd6
`define UPAG_HIGH8_FIRST 8'hf8
`define UPAG_CFG_LAST 8'hc7

// enable bit positions
`define UPAG_BIT_T5_D0 3'd7
`define UPAG_BIT_T5_F8 3'd6
`define UPAG_BIT_CFG_80 3'd5
`define UPAG_BIT_LO_F8 3'd4
`define UPAG_BIT_LO_80 3'd3
`define UPAG_BIT_LOWER 3'd2
`define UPAG_BIT_AUX_HI 3'd1
`define UPAG_BIT_AUX_LO 3'd0

`endif

// ===== src/upag_guard.sv
`timescale 1ns/10ps
`include "upag_defines.svh"

module upag_guard
    import upag_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic alt_map_in,
    input wire logic [31:0] entered_password_in,
    input wire logic acc_valid_in,
    input wire logic acc_write_in,
    input wire logic acc_aux_in,
    input wire logic [7:0] acc_table_in,
    input wire logic [7:0] acc_addr_in,
    input wire logic [7:0] acc_wdata_in,
    input wire logic nv_restore_valid_in,
    input wire logic [7:0] nv_restore_addr_in,
    input wire logic [7:0] nv_restore_data_in,
    input wire logic nv_restore_done_in,
    output logic acc_done_out,
    output logic acc_permit_out,
    output logic acc_own_out,
    output logic [7:0] acc_rdata_out,
    output logic [7:0] table_select_out,
    output logic nv_store_out,
    output logic [7:0] nv_addr_out,
    output logic [7:0] nv_data_out
);

    upag_byte_t wr_enables;
    upag_byte_t rd_enables;
    logic [31:0] password;
    upag_byte_t tsel_default;

    // configuration table follows the memory-map compatibility choice
    function automatic upag_byte_t cfg_table(input logic alt);
        cfg_table = alt ? `UPAG_TBL_01 : `UPAG_TBL_04;
    endfunction

    function automatic upag_byte_t low_table(input logic alt);
        low_table = alt ? `UPAG_TBL_00 : `UPAG_TBL_01;
    endfunction

    // which protection block an address belongs to, if any
    function automatic upag_blk_s block_of(input logic aux, input upag_byte_t tbl,
                                           input upag_byte_t a, input logic alt);
        upag_blk_s r;
        r.hit = 1'b0;
        r.idx = 3'd0;
        if (aux) begin
            r.hit = 1'b1;
            r.idx = (a >= `UPAG_UPPER_BASE) ? `UPAG_BIT_AUX_HI : `UPAG_BIT_AUX_LO;
        end else if (a < `UPAG_UPPER_BASE) begin
            if (a <= `UPAG_LOWER_LAST) begin
                r.hit = 1'b1;
                r.idx = `UPAG_BIT_LOWER;
            end
        end else if (tbl == `UPAG_TBL_05) begin
            if (a >= `UPAG_T5A_FIRST && a <= `UPAG_T5A_LAST) begin
                r.hit = 1'b1;
                r.idx = `UPAG_BIT_T5_D0;
            end else if (a >= `UPAG_HIGH8_FIRST) begin
                r.hit = 1'b1;
                r.idx = `UPAG_BIT_T5_F8;
            end
        end else if (tbl == cfg_table(alt) || tbl == `UPAG_TBL_02 || tbl == `UPAG_TBL_03) begin
            if (a <= `UPAG_CFG_LAST) begin
                r.hit = 1'b1;
                r.idx = `UPAG_BIT_CFG_80;
            end
        end else if (tbl == low_table(alt)) begin
            r.hit = 1'b1;
            r.idx = (a >= `UPAG_HIGH8_FIRST) ? `UPAG_BIT_LO_F8 : `UPAG_BIT_LO_80;
        end
        block_of = r;
    endfunction

    function automatic logic own_reg(input logic aux, input upag_byte_t tbl,
                                     input upag_byte_t a, input logic alt);
        own_reg = !aux && tbl == cfg_table(alt) && a >= `UPAG_OFS_WR_EN && a <= `UPAG_OFS_TSEL_DEF;
    endfunction

    upag_blk_s blk;
    logic unlocked;
    logic locked_wr;
    logic locked_rd;
    logic permit;
    logic own_hit;
    logic own_wr;
    upag_byte_t own_rdata;
    logic shadow_we;
    upag_byte_t shadow_addr;
    upag_byte_t shadow_data;

    assign blk = block_of(acc_aux_in, acc_table_in, acc_addr_in, alt_map_in);
    assign unlocked = (entered_password_in == password);
    assign locked_wr = blk.hit && wr_enables[blk.idx] && !unlocked;
    assign locked_rd = blk.hit && rd_enables[blk.idx] && !unlocked;
    assign permit = acc_write_in ? !locked_wr : !locked_rd;
    assign own_hit = own_reg(acc_aux_in, acc_table_in, acc_addr_in, alt_map_in);
    assign own_wr = acc_valid_in && acc_write_in && own_hit && permit;
    assign shadow_we = own_wr || nv_restore_valid_in;
    // host write wins over a restore in the same cycle
    assign shadow_addr = own_wr ? acc_addr_in : nv_restore_addr_in;
    assign shadow_data = own_wr ? acc_wdata_in : nv_restore_data_in;

    always_comb begin
        unique case (acc_addr_in)
            `UPAG_OFS_WR_EN: own_rdata = wr_enables;
            `UPAG_OFS_RD_EN: own_rdata = rd_enables;
            `UPAG_OFS_PW_B3: own_rdata = password[31:24];
            `UPAG_OFS_PW_B2: own_rdata = password[23:16];
            `UPAG_OFS_PW_B1: own_rdata = password[15:8];
            `UPAG_OFS_PW_B0: own_rdata = password[7:0];
            `UPAG_OFS_TSEL_DEF: own_rdata = tsel_default;
            default: own_rdata = 8'h00;
        endcase
    end

    // shadow registers: host writes when permitted, nonvolatile restore otherwise
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wr_enables <= `UPAG_RST_WR_EN;
            rd_enables <= `UPAG_RST_RD_EN;
            password <= `UPAG_RST_PW;
            tsel_default <= `UPAG_RST_TSEL_DEF;
        end else if (shadow_we) begin
            unique case (shadow_addr)
                `UPAG_OFS_WR_EN: wr_enables <= shadow_data;
                `UPAG_OFS_RD_EN: rd_enables <= shadow_data;
                `UPAG_OFS_PW_B3: password[31:24] <= shadow_data;
                `UPAG_OFS_PW_B2: password[23:16] <= shadow_data;
                `UPAG_OFS_PW_B1: password[15:8] <= shadow_data;
                `UPAG_OFS_PW_B0: password[7:0] <= shadow_data;
                `UPAG_OFS_TSEL_DEF: tsel_default <= shadow_data;
                default: ;
            endcase
        end
    end

    // every accepted write to the own configuration registers is mirrored to nonvolatile storage
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            nv_store_out <= 1'b0;
            nv_addr_out <= 8'h00;
            nv_data_out <= 8'h00;
        end else begin
            nv_store_out <= own_wr;
            if (own_wr) begin
                nv_addr_out <= acc_addr_in;
                nv_data_out <= acc_wdata_in;
            end
        end
    end

    // access answer, one cycle after the request
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            acc_done_out <= 1'b0;
            acc_permit_out <= 1'b0;
            acc_own_out <= 1'b0;
            acc_rdata_out <= 8'h00;
        end else begin
            acc_done_out <= acc_valid_in;
            if (acc_valid_in) begin
                acc_permit_out <= permit;
                acc_own_out <= own_hit;
                acc_rdata_out <= (!acc_write_in && own_hit && permit) ? own_rdata : 8'h00;
            end
        end
    end

    // table select byte: loaded from the default once restore completes, host writable in any other cycle
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            table_select_out <= `UPAG_RST_TSEL_DEF;
        end else if (nv_restore_done_in) begin
            table_select_out <= tsel_default;
        end else if (acc_valid_in && acc_write_in && !acc_aux_in && acc_addr_in == `UPAG_TSEL_ADDR) begin
            table_select_out <= acc_wdata_in;
        end
    end

    sequence s_locked_write;
        acc_valid_in && acc_write_in && blk.hit && wr_enables[blk.idx] && !unlocked;
    endsequence

    sequence s_locked_read;
        acc_valid_in && !acc_write_in && blk.hit && rd_enables[blk.idx] && !unlocked;
    endsequence

    sequence s_denied_answer;
        acc_done_out && !acc_permit_out;
    endsequence

    a_write_guard_deny: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_locked_write |=> s_denied_answer)
        else $error("locked write was permitted");

    a_read_guard_deny: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_locked_read |=> s_denied_answer ##0 acc_rdata_out == 8'h00)
        else $error("locked read was permitted or leaked data");

    a_unlock_grants_all: assert property (@(posedge clk_in) disable iff (!nrst_in)
        acc_valid_in && entered_password_in == password |=> acc_done_out && acc_permit_out)
        else $error("matching password did not grant access");

    a_denied_no_store: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_locked_write ##0 !nv_restore_valid_in |=> $stable(password) && $stable(wr_enables)
            && $stable(rd_enables) && !nv_store_out)
        else $error("denied write changed stored state");

    a_pw_byte_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
        own_wr && acc_addr_in == `UPAG_OFS_PW_B3 |=> password[31:24] == $past(acc_wdata_in))
        else $error("password high byte not at lowest address");

    a_nv_mirror_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
        own_wr |=> nv_store_out && nv_addr_out == $past(acc_addr_in) && nv_data_out == $past(acc_wdata_in))
        else $error("accepted write not mirrored to nonvolatile store");

    a_tsel_powerup_copy: assert property (@(posedge clk_in) disable iff (!nrst_in)
        nv_restore_done_in |=> table_select_out == $past(tsel_default))
        else $error("table select not loaded from default");

    a_aux_high_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
        acc_valid_in && acc_aux_in && acc_addr_in[7] && acc_write_in && wr_enables[1] && !unlocked
            |=> !acc_permit_out)
        else $error("auxiliary upper block write not guarded");

    a_lower_block_map: assert property (@(posedge clk_in) disable iff (!nrst_in)
        acc_valid_in && !acc_aux_in && acc_addr_in <= `UPAG_LOWER_LAST && !acc_write_in
            && rd_enables[`UPAG_BIT_LOWER] && !unlocked |=> s_denied_answer)
        else $error("lower memory read not guarded by bit 2");

    sequence s_guarded_read;
        acc_valid_in && !acc_write_in && !unlocked;
    endsequence

    sequence s_granted_answer;
        acc_done_out && acc_permit_out;
    endsequence

    a_aux_low_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_guarded_read ##0 (acc_aux_in && !acc_addr_in[7] && rd_enables[`UPAG_BIT_AUX_LO])
            |=> s_denied_answer)
        else $error("auxiliary lower block read not guarded");

    a_t5_d0_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_guarded_read ##0 (!acc_aux_in && acc_table_in == 8'h05 && acc_addr_in >= 8'hd0
            && acc_addr_in <= 8'hd6 && rd_enables[7]) |=> s_denied_answer)
        else $error("table five first block read not guarded");

    a_t5_f8_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_guarded_read ##0 (!acc_aux_in && acc_table_in == 8'h05 && acc_addr_in >= 8'hf8
            && rd_enables[6]) |=> s_denied_answer)
        else $error("table five last block read not guarded");

    a_cfg_block_guard: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_guarded_read ##0 (!acc_aux_in && (acc_table_in == 8'h02 || acc_table_in == 8'h03
            || acc_table_in == (alt_map_in ? 8'h01 : 8'h04)) && acc_addr_in[7] && acc_addr_in <= 8'hc7
            && rd_enables[5]) |=> s_denied_answer)
        else $error("configuration block read not guarded");

    a_low_high_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_guarded_read ##0 (!acc_aux_in && acc_table_in == (alt_map_in ? 8'h00 : 8'h01)
            && acc_addr_in >= 8'hf8 && rd_enables[4]) |=> s_denied_answer)
        else $error("low table last block read not guarded");

    a_low_main_block: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_guarded_read ##0 (!acc_aux_in && acc_table_in == (alt_map_in ? 8'h00 : 8'h01)
            && acc_addr_in[7] && acc_addr_in < 8'hf8 && rd_enables[3]) |=> s_denied_answer)
        else $error("low table main block read not guarded");

    a_factory_enables: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> wr_enables == 8'h00 && rd_enables == 8'h00
            && password == 32'h0000_0000)
        else $error("enables or password not at factory value after reset");

    a_factory_tsel: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> tsel_default == 8'h01 && table_select_out == 8'h01)
        else $error("table select default not one after reset");

    a_pw_low_byte: assert property (@(posedge clk_in) disable iff (!nrst_in)
        own_wr && acc_addr_in == `UPAG_OFS_PW_B0 |=> password[7:0] == $past(acc_wdata_in))
        else $error("password low byte not at highest address");

    a_restore_shadow: assert property (@(posedge clk_in) disable iff (!nrst_in)
        nv_restore_valid_in && !own_wr && nv_restore_addr_in == `UPAG_OFS_RD_EN |=> rd_enables == $past(nv_restore_data_in))
        else $error("restored byte not loaded into shadow");

    a_cfg_map_select: assert property (@(posedge clk_in) disable iff (!nrst_in)
        acc_valid_in && !acc_write_in && !acc_aux_in && acc_addr_in == `UPAG_OFS_WR_EN
            && acc_table_in == (alt_map_in ? 8'h01 : 8'h04) && (unlocked || !rd_enables[5])
            |=> s_granted_answer ##0 (acc_own_out && acc_rdata_out == $past(wr_enables)))
        else $error("own register not found in selected configuration table");

endmodule

// ===== src/upag_pkg.sv
package upag_pkg;

    typedef logic [7:0] upag_byte_t;

    // block lookup result: valid flag and enable-bit index
    typedef struct packed {
        logic hit;
        logic [2:0] idx;
    } upag_blk_s;

endpackage
